// *** bench/iafc_flow_comparator_asserts.sv ***
// port assertions for the flow comparator
`timescale 1ns/1ps
module iafc_flow_comparator_asserts #(
    parameter int NUM_FLOWS = 8
) (
    // clock, reset, enable
    input logic                 CLK_SYS_IN,
    input logic                 NRST_IN,
    input logic                 CE_IN,
    // apb
    input logic                 PSEL_IN,
    input logic                 PENABLE_IN,
    input logic [31:0]          PRDATA_OUT,
    input logic                 PREADY_OUT,
    input logic                 PSLVERR_OUT,
    // byte streams
    input logic                 BYTE_VALID_IN,
    input logic                 BYTE_FIRST_IN,
    input logic                 BYTE_LAST_IN,
    input logic [7:0]           BYTE_DATA_IN,
    input logic                 BYTE_VALID_OUT,
    input logic                 BYTE_FIRST_OUT,
    input logic                 BYTE_LAST_OUT,
    input logic [7:0]           BYTE_DATA_OUT,
    // results
    input logic                 MATCH_VALID_OUT,
    input logic [NUM_FLOWS-1:0] FLOW_MATCH_OUT,
    input logic [7:0]           SUM_POS_OUT
);
    logic in_frame;
    logic taken;
    assign taken = CE_IN && BYTE_VALID_IN && (BYTE_FIRST_IN || in_frame);
    // own frame tracking, so stray bytes outside a frame stay visible
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            in_frame <= 1'b0;
        end else if (taken) begin
            in_frame <= !BYTE_LAST_IN;
        end
    end
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!NRST_IN);
    a_byte_copy: assert property (
        taken |=> BYTE_VALID_OUT && BYTE_FIRST_OUT == $past(BYTE_FIRST_IN) && BYTE_LAST_OUT == $past(BYTE_LAST_IN))
        else $error("byte not copied");
    a_no_stray: assert property (
        CE_IN && !taken |=> !BYTE_VALID_OUT) else $error("stray byte out");
    a_data_pass: assert property (
        taken |=> BYTE_DATA_OUT == $past(BYTE_DATA_IN) || BYTE_DATA_OUT == 8'h00) else $error("byte corrupted");
    a_match_after_last: assert property (
        taken && BYTE_LAST_IN |=> MATCH_VALID_OUT) else $error("no result after last byte");
    a_match_cause: assert property (
        MATCH_VALID_OUT |-> BYTE_LAST_OUT) else $error("result without frame end");
    a_result_hold: assert property (
        !MATCH_VALID_OUT |-> $stable(FLOW_MATCH_OUT) && $stable(SUM_POS_OUT)) else $error("result moved");
    a_ready_setup: assert property (
        PSEL_IN && !PENABLE_IN && CE_IN |=> PREADY_OUT) else $error("no ready after setup");
    a_ready_pulse: assert property (
        CE_IN && PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
    a_err_ready: assert property (
        PSLVERR_OUT |-> PREADY_OUT && PSEL_IN && PENABLE_IN) else $error("error outside access");
    a_rdata_idle: assert property (
        !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000) else $error("read data outside access");
    c_hit: cover property (MATCH_VALID_OUT && FLOW_MATCH_OUT[0]);
    c_err: cover property (PSLVERR_OUT);
    c_last: cover property (BYTE_LAST_OUT && BYTE_VALID_OUT);
endmodule : iafc_flow_comparator_asserts

bind iafc_flow_comparator iafc_flow_comparator_asserts #(.NUM_FLOWS(NUM_FLOWS)) u_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .BYTE_VALID_IN(BYTE_VALID_IN),
    .BYTE_FIRST_IN(BYTE_FIRST_IN), .BYTE_LAST_IN(BYTE_LAST_IN), .BYTE_DATA_IN(BYTE_DATA_IN),
    .BYTE_VALID_OUT(BYTE_VALID_OUT), .BYTE_FIRST_OUT(BYTE_FIRST_OUT), .BYTE_LAST_OUT(BYTE_LAST_OUT),
    .BYTE_DATA_OUT(BYTE_DATA_OUT), .MATCH_VALID_OUT(MATCH_VALID_OUT), .FLOW_MATCH_OUT(FLOW_MATCH_OUT),
    .SUM_POS_OUT(SUM_POS_OUT));

// *** bench/iafc_flow_comparator_tb.sv ***
// self-checking bench for the flow comparator
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module iafc_flow_comparator_tb;
    typedef struct packed {logic [31:0] ctrl; logic [31:0] cfg; logic chan; logic hit;} iafc_row_s;
    iafc_row_s   rows [8] = '{
        '{32'h0000_0C20, 32'h0000_0101, 1'b0, 1'b1},
        '{32'h0000_0C20, 32'h0000_0103, 1'b0, 1'b0},
        '{32'h0000_0C20, 32'h0000_0105, 1'b0, 1'b1},
        '{32'h0000_0C20, 32'h0000_0101, 1'b1, 1'b0},
        '{32'h0000_0C20, 32'h0000_0100, 1'b0, 1'b0},
        '{32'h0000_0C22, 32'h0000_0103, 1'b0, 1'b1},
        '{32'h0000_0C21, 32'h0000_0105, 1'b0, 1'b1},
        '{32'h0000_0C23, 32'h0000_0101, 1'b0, 1'b1}};
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, start = 0, chan = 0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, bv, bf, bl, ov, of, mv, szero, sfix, spv;
    logic [7:0]  bd, od, spos, frm [64], ob [64];
    logic [7:0]  fm;
    logic [63:0] key;
    logic [1:0]  slen;
    logic [4:0]  sig;
    int          k, oi, errors = 0, samples_checked = 0;
    always #25 clk = ~clk;
    iafc_hdr_source u_src (.clk_in(clk), .start_in(start), .len_in(8'h30), .frame_in(frm), .valid_out(bv),
        .first_out(bf), .last_out(bl), .data_out(bd), .busy_out());
    iafc_flow_comparator u_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .BYTE_VALID_IN(bv), .BYTE_FIRST_IN(bf), .BYTE_LAST_IN(bl), .BYTE_DATA_IN(bd),
        .CHAN_IN(chan), .BYTE_VALID_OUT(ov), .BYTE_FIRST_OUT(of), .BYTE_LAST_OUT(), .BYTE_DATA_OUT(od),
        .MATCH_VALID_OUT(mv), .FLOW_MATCH_OUT(fm), .PTP_KEY_OUT(key), .SUM_ZERO_OUT(szero), .SUM_FIX_OUT(sfix),
        .SUM_POS_OUT(spos), .SUM_POS_VALID_OUT(spv), .SUM_LEN_OUT(slen), .SIG_POS_OUT(sig));
    always @(posedge clk) begin
        if (ov === 1'b1) begin
            oi = (of === 1'b1) ? 0 : oi + 1;
            ob[oi[5:0]] = od;
        end
    end
    task automatic end_of_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic send(input logic c);
        @(posedge clk);
        chan  <= c;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 200 && mv !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (mv !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask : send
    initial begin
        for (k = 0; k < 64; k++) begin
            frm[k] = 8'(k);
        end
        {frm[12], frm[13], frm[14], frm[15]} = 32'h0A00_0001;
        {frm[16], frm[17], frm[18], frm[19]} = 32'h0A00_0002;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b1, 12'h41C, 32'h0A00_0001);
        apb(1'b1, 12'h42C, 32'hFFFF_FFFF);
        apb(1'b1, 12'h004, 32'h0000_1C1A);
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, rows[i].ctrl);
            apb(1'b1, 12'h400, rows[i].cfg);
            send(rows[i].chan);
            `CHK(fm, {7'h00, rows[i].hit})
            $display("row %0d done", i);
        end
        // only one of the two checksum enables at a time
        apb(1'b1, 12'h000, 32'h0005_0C24);
        send(1'b0);
        `CHK({ob[25], ob[26], ob[27], ob[28]}, 32'h1900_001C)
        `CHK({szero, sfix, spv, slen}, 5'b10110)
        `CHK(spos, 8'h1A)
        `CHK(sig, 5'h05)
        `CHK(key, 64'h1C1D_1E1F_2021_2223)
        apb(1'b1, 12'h000, 32'h0000_0C28);
        send(1'b0);
        `CHK({ob[26], ob[27], szero, sfix}, {8'h1A, 8'h1B, 2'b01})
        $display("checksum options done");
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0001)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK({rerr, rdat}, 33'h1_0000_0000)
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0020)
        apb(1'b0, 12'h400, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000)
        $display("reset and refusal done");
        end_of_test();
    end
endmodule : iafc_flow_comparator_tb

// *** bench/iafc_hdr_source.sv ***
// upstream comparator model: sends one stored header as a byte stream
`timescale 1ns/1ps
module iafc_hdr_source (
    // control
    input  logic       clk_in,
    input  logic       start_in,
    input  logic [7:0] len_in,
    input  logic [7:0] frame_in [64],
    // stream
    output logic       valid_out,
    output logic       first_out,
    output logic       last_out,
    output logic [7:0] data_out,
    output logic       busy_out
);
    logic [7:0] idx = 8'h00;
    initial begin
        {valid_out, first_out, last_out, busy_out, data_out} = 12'h000;
    end
    always @(posedge clk_in) begin
        if (busy_out) begin
            valid_out <= 1'b1;
            first_out <= (idx == 8'h00);
            last_out  <= (idx == len_in - 8'h01);
            data_out  <= frame_in[idx];
            idx       <= idx + 8'h01;
            busy_out  <= (idx != len_in - 8'h01);
        end else begin
            {valid_out, first_out, last_out} <= 3'b000;
            // released line toggles so a stale byte is never mistaken for data
            data_out <= ~data_out;
            busy_out <= start_in;
            idx      <= 8'h00;
        end
    end
endmodule : iafc_hdr_source

// *** design/iafc_cfg.svh ***
// register map, field positions, reset values and encodings of the flow comparator
`ifndef IAFC_CFG_SVH
`define IAFC_CFG_SVH

`define IAFC_ADDR_W          12
`define IAFC_CTRL_ADDR       12'h000
`define IAFC_SUM_ADDR        12'h004
`define IAFC_STATUS_ADDR     12'h008
`define IAFC_FLOW_REGION     2'b01
`define IAFC_FLOW_CFG_WORD   4'h0
`define IAFC_FLOW_VAL_WORD   2'b01
`define IAFC_FLOW_MSK_WORD   2'b10

`define IAFC_CTRL_MODE_LSB   0
`define IAFC_CTRL_ZERO_BIT   2
`define IAFC_CTRL_FIX_BIT    3
`define IAFC_CTRL_LEN_LSB    4
`define IAFC_CTRL_FPOS_LSB   8
`define IAFC_CTRL_SIG_LSB    16
`define IAFC_SUM_POS_LSB     0
`define IAFC_SUM_NXT_LSB     8
`define IAFC_FCFG_ENA_BIT    0
`define IAFC_FCFG_SEL_LSB    1
`define IAFC_FCFG_CHAN_LSB   8

`define IAFC_RST_MODE        2'h0
`define IAFC_RST_SUM_LEN     2'h2
`define IAFC_RST_BYTE        8'h00
`define IAFC_RST_POS5        5'h00

`define IAFC_SEL_SRC         2'h0
`define IAFC_SEL_DST         2'h1
`define IAFC_SEL_EITHER      2'h2

`define IAFC_LEN_SHORT       8'h04
`define IAFC_LEN_LONG        8'h10
`define IAFC_KEY_BYTES       8'h08
`define IAFC_UPPER32_MASK    {32'hFFFF_FFFF, 96'h0}
`define IAFC_IDX_MAX         8'hFF

`endif

// *** design/iafc_flow_comparator.sv ***
// ip/udp/ach flow comparator with apb registers, checksum zeroing and stage hand-off
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "iafc_cfg.svh"

module iafc_flow_comparator #(
    parameter int NUM_FLOWS = 8,
    parameter int NUM_CHAN  = 2,
    parameter int HAS_SIG   = 1
) (
    // clock, reset, enable
    input  wire logic                          CLK_SYS_IN,
    input  wire logic                          NRST_IN,
    input  wire logic                          CE_IN,
    // apb slave
    input  wire logic                          PSEL_IN,
    input  wire logic                          PENABLE_IN,
    input  wire logic                          PWRITE_IN,
    input  wire logic [`IAFC_ADDR_W-1:0]       PADDR_IN,
    input  wire logic [31:0]                   PWDATA_IN,
    output logic      [31:0]                   PRDATA_OUT,
    output logic                               PREADY_OUT,
    output logic                               PSLVERR_OUT,
    // header byte stream from the previous comparator
    input  wire logic                          BYTE_VALID_IN,
    input  wire logic                          BYTE_FIRST_IN,
    input  wire logic                          BYTE_LAST_IN,
    input  wire logic [7:0]                    BYTE_DATA_IN,
    input  wire logic [$clog2(NUM_CHAN)-1:0]   CHAN_IN,
    // byte stream to the ptp/oam stage
    output logic                               BYTE_VALID_OUT,
    output logic                               BYTE_FIRST_OUT,
    output logic                               BYTE_LAST_OUT,
    output logic      [7:0]                    BYTE_DATA_OUT,
    // per-frame result for the ptp/oam stage
    output logic                               MATCH_VALID_OUT,
    output logic      [NUM_FLOWS-1:0]          FLOW_MATCH_OUT,
    output logic      [63:0]                   PTP_KEY_OUT,
    output logic                               SUM_ZERO_OUT,
    output logic                               SUM_FIX_OUT,
    output logic      [7:0]                    SUM_POS_OUT,
    output logic                               SUM_POS_VALID_OUT,
    output logic      [1:0]                    SUM_LEN_OUT,
    output logic      [4:0]                    SIG_POS_OUT
);

    localparam int FW = $clog2(NUM_FLOWS) > 0 ? $clog2(NUM_FLOWS) : 1;

    // global configuration
    iafc_pkg::iafc_mode_e                comparator_protocol_select;
    logic                                udp_sum_zero_enable;
    logic                                udp_sum_fix_enable;
    logic [7:0]                          udp_sum_position;
    logic [1:0]                          udp_sum_length;
    logic [4:0]                          flow_field_position;
    logic [4:0]                          signature_field_position;
    logic [7:0]                          next_header_start;
    // per-flow configuration
    logic                                flow_enable_bit     [NUM_FLOWS];
    logic [1:0]                          address_select      [NUM_FLOWS];
    logic [NUM_CHAN-1:0]                 flow_channel_enable [NUM_FLOWS];
    iafc_pkg::iafc_field_t               flow_compare_value  [NUM_FLOWS];
    iafc_pkg::iafc_field_t               flow_compare_mask   [NUM_FLOWS];

    // apb decode
    logic                                apb_setup;
    logic                                apb_write;
    logic                                flow_hit;
    logic [FW-1:0]                       flow_idx;
    logic [3:0]                          word_idx;
    logic                                addr_ok;
    logic [31:0]                         next_prdata;

    // capture state
    iafc_pkg::iafc_state_e               state;
    logic [7:0]                          byte_cnt;
    logic [7:0]                          cur_idx;
    logic [7:0]                          rel_src;
    logic [7:0]                          rel_dst;
    logic [7:0]                          rel_key;
    logic [7:0]                          field_len;
    logic                                take;
    logic [$clog2(NUM_CHAN)-1:0]         frame_chan;
    iafc_pkg::iafc_field_t               src_field;
    iafc_pkg::iafc_field_t               dst_field;
    logic [63:0]                         key_field;

    // frame result
    logic [NUM_FLOWS-1:0]                next_match;
    logic [63:0]                         key_now;
    logic [NUM_FLOWS-1:0]                last_match;
    logic                                in_sum_bytes;

    assign apb_setup = PSEL_IN && !PENABLE_IN;
    // refused writes change nothing
    assign apb_write = PSEL_IN && PENABLE_IN && PWRITE_IN &&
                       PREADY_OUT && !PSLVERR_OUT;
    assign flow_hit  = (PADDR_IN[11:10] == `IAFC_FLOW_REGION) && (32'(PADDR_IN[9:6]) < NUM_FLOWS);
    assign flow_idx  = FW'(PADDR_IN[9:6]);
    assign word_idx  = PADDR_IN[5:2];

    always_comb begin
        addr_ok     = 1'b0;
        next_prdata = 32'h0000_0000;

        if (PADDR_IN == `IAFC_CTRL_ADDR) begin
            addr_ok = 1'b1;
            next_prdata[`IAFC_CTRL_MODE_LSB +: 2] = comparator_protocol_select;
            next_prdata[`IAFC_CTRL_ZERO_BIT]      = udp_sum_zero_enable;
            next_prdata[`IAFC_CTRL_FIX_BIT]       = udp_sum_fix_enable;
            next_prdata[`IAFC_CTRL_LEN_LSB +: 2]  = udp_sum_length;
            next_prdata[`IAFC_CTRL_FPOS_LSB +: 5] = flow_field_position;
            next_prdata[`IAFC_CTRL_SIG_LSB +: 5]  = signature_field_position;
        end else if (PADDR_IN == `IAFC_SUM_ADDR) begin
            addr_ok = 1'b1;
            next_prdata[`IAFC_SUM_POS_LSB +: 8] = udp_sum_position;
            next_prdata[`IAFC_SUM_NXT_LSB +: 8] = next_header_start;
        end else if (PADDR_IN == `IAFC_STATUS_ADDR) begin
            addr_ok = 1'b1;
            next_prdata[NUM_FLOWS-1:0] = last_match;
            next_prdata[31]            = (state == iafc_pkg::ST_FRAME);
        end else if (flow_hit && PADDR_IN[1:0] == 2'b00) begin
            if (word_idx == `IAFC_FLOW_CFG_WORD) begin
                addr_ok = 1'b1;
                next_prdata[`IAFC_FCFG_ENA_BIT]            = flow_enable_bit[flow_idx];
                next_prdata[`IAFC_FCFG_SEL_LSB +: 2]       = address_select[flow_idx];
                next_prdata[`IAFC_FCFG_CHAN_LSB +: NUM_CHAN] = flow_channel_enable[flow_idx];
            end else if (word_idx[3:2] == `IAFC_FLOW_VAL_WORD) begin
                addr_ok     = 1'b1;
                next_prdata = flow_compare_value[flow_idx][{word_idx[1:0], 5'h00} +: 32];
            end else if (word_idx[3:2] == `IAFC_FLOW_MSK_WORD) begin
                addr_ok     = 1'b1;
                next_prdata = flow_compare_mask[flow_idx][{word_idx[1:0], 5'h00} +: 32];
            end
        end
    end

    // answer is prepared in the setup cycle, so every access completes without wait states
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
        end else if (CE_IN) begin
            PREADY_OUT  <= apb_setup;
            PSLVERR_OUT <= apb_setup && !addr_ok;
            PRDATA_OUT  <= (apb_setup && !PWRITE_IN && addr_ok) ? next_prdata : 32'h0000_0000;
        end
    end

    // global registers; zero and fix stay independent, software keeps them exclusive
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            comparator_protocol_select <= iafc_pkg::MODE_IPV4;
            udp_sum_zero_enable        <= 1'b0;
            udp_sum_fix_enable         <= 1'b0;
            udp_sum_length             <= `IAFC_RST_SUM_LEN;
            flow_field_position        <= `IAFC_RST_POS5;
            signature_field_position   <= `IAFC_RST_POS5;
            udp_sum_position           <= `IAFC_RST_BYTE;
            next_header_start          <= `IAFC_RST_BYTE;
        end else if (CE_IN && apb_write) begin
            if (PADDR_IN == `IAFC_CTRL_ADDR) begin
                comparator_protocol_select <= iafc_pkg::iafc_mode_e'(PWDATA_IN[`IAFC_CTRL_MODE_LSB +: 2]);
                udp_sum_zero_enable        <= PWDATA_IN[`IAFC_CTRL_ZERO_BIT];
                udp_sum_fix_enable         <= PWDATA_IN[`IAFC_CTRL_FIX_BIT];
                udp_sum_length             <= PWDATA_IN[`IAFC_CTRL_LEN_LSB +: 2];
                flow_field_position        <= PWDATA_IN[`IAFC_CTRL_FPOS_LSB +: 5];
                // without a signature fifo the field does not exist and reads zero
                signature_field_position   <= (HAS_SIG != 0) ? PWDATA_IN[`IAFC_CTRL_SIG_LSB +: 5] : `IAFC_RST_POS5;
            end

            if (PADDR_IN == `IAFC_SUM_ADDR) begin
                udp_sum_position  <= PWDATA_IN[`IAFC_SUM_POS_LSB +: 8];
                next_header_start <= PWDATA_IN[`IAFC_SUM_NXT_LSB +: 8];
            end
        end
    end

    // per-flow registers
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            for (int f = 0; f < NUM_FLOWS; f++) begin
                flow_enable_bit[f]     <= 1'b0;
                address_select[f]      <= `IAFC_SEL_SRC;
                flow_channel_enable[f] <= '0;
                flow_compare_value[f]  <= '0;
                flow_compare_mask[f]   <= '0;
            end
        end else if (CE_IN && apb_write && flow_hit) begin
            if (word_idx == `IAFC_FLOW_CFG_WORD) begin
                flow_enable_bit[flow_idx]     <= PWDATA_IN[`IAFC_FCFG_ENA_BIT];
                address_select[flow_idx]      <= PWDATA_IN[`IAFC_FCFG_SEL_LSB +: 2];
                flow_channel_enable[flow_idx] <= PWDATA_IN[`IAFC_FCFG_CHAN_LSB +: NUM_CHAN];
            end else if (word_idx[3:2] == `IAFC_FLOW_VAL_WORD) begin
                flow_compare_value[flow_idx][{word_idx[1:0], 5'h00} +: 32] <= PWDATA_IN;
            end else if (word_idx[3:2] == `IAFC_FLOW_MSK_WORD) begin
                flow_compare_mask[flow_idx][{word_idx[1:0], 5'h00} +: 32] <= PWDATA_IN;
            end
        end
    end

    // byte position within the frame, counted from the ip header start
    assign take      = BYTE_VALID_IN && (BYTE_FIRST_IN || state == iafc_pkg::ST_FRAME);
    assign cur_idx   = BYTE_FIRST_IN ? 8'h00 : byte_cnt;
    assign field_len = (comparator_protocol_select == iafc_pkg::MODE_IPV4 ||
                        comparator_protocol_select == iafc_pkg::MODE_OTHER32) ? `IAFC_LEN_SHORT : `IAFC_LEN_LONG;
    assign rel_src   = cur_idx - {3'b000, flow_field_position};
    assign rel_dst   = rel_src - field_len;
    assign rel_key   = cur_idx - next_header_start;
    // only ipv4 has a header-relative checksum position
    assign in_sum_bytes = (comparator_protocol_select == iafc_pkg::MODE_IPV4) &&
                          (cur_idx >= udp_sum_position) &&
                          ((cur_idx - udp_sum_position) < {6'h00, udp_sum_length});

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state      <= iafc_pkg::ST_IDLE;
            byte_cnt   <= 8'h00;
            frame_chan <= '0;
        end else if (CE_IN && take) begin
            // saturate, never wrap
            byte_cnt <= (cur_idx == `IAFC_IDX_MAX) ? cur_idx : cur_idx + 8'h01;
            if (BYTE_FIRST_IN) begin
                frame_chan <= CHAN_IN;
            end

            case (state)
                iafc_pkg::ST_IDLE:  state <= BYTE_LAST_IN ? iafc_pkg::ST_IDLE : iafc_pkg::ST_FRAME;
                iafc_pkg::ST_FRAME: state <= BYTE_LAST_IN ? iafc_pkg::ST_IDLE : iafc_pkg::ST_FRAME;
                default:            state <= iafc_pkg::ST_IDLE;
            endcase
        end
    end

    // field capture; first captured byte lands in the top byte so ipv4 fills bits 127:96
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            src_field <= '0;
            dst_field <= '0;
            key_field <= 64'h0;
        end else if (CE_IN && take) begin
            if (BYTE_FIRST_IN) begin
                src_field <= '0;
                dst_field <= '0;
                key_field <= 64'h0;
            end
            if (rel_src < field_len) begin
                src_field[{~rel_src[3:0], 3'b000} +: 8] <= BYTE_DATA_IN;
            end else if (rel_dst < field_len) begin
                dst_field[{~rel_dst[3:0], 3'b000} +: 8] <= BYTE_DATA_IN;
            end
            if (cur_idx >= next_header_start && rel_key < `IAFC_KEY_BYTES) begin
                key_field[{~rel_key[2:0], 3'b000} +: 8] <= BYTE_DATA_IN;
            end
        end
    end

    // the last byte is folded into the fields here so the verdict leaves with it
    always_comb begin
        iafc_pkg::iafc_field_t src_now;
        iafc_pkg::iafc_field_t dst_now;
        iafc_pkg::iafc_field_t eff_mask;
        logic                  src_eq;
        logic                  dst_eq;
        logic                  addr_eq;

        src_now  = BYTE_FIRST_IN ? '0 : src_field;
        dst_now  = BYTE_FIRST_IN ? '0 : dst_field;
        eff_mask = '0;
        src_eq   = 1'b0;
        dst_eq   = 1'b0;
        addr_eq  = 1'b0;
        // no stale key on a one-byte frame
        key_now  = BYTE_FIRST_IN ? 64'h0 : key_field;
        if (cur_idx >= next_header_start && rel_key < `IAFC_KEY_BYTES) begin
            key_now[{~rel_key[2:0], 3'b000} +: 8] = BYTE_DATA_IN;
        end

        if (rel_src < field_len) begin
            src_now[{~rel_src[3:0], 3'b000} +: 8] = BYTE_DATA_IN;
        end else if (rel_dst < field_len) begin
            dst_now[{~rel_dst[3:0], 3'b000} +: 8] = BYTE_DATA_IN;
        end

        for (int f = 0; f < NUM_FLOWS; f++) begin
            // short modes compare the upper 32 bits only, the rest of the value is unused
            eff_mask = (field_len == `IAFC_LEN_SHORT) ? (flow_compare_mask[f] & `IAFC_UPPER32_MASK)
                                                      : flow_compare_mask[f];
            src_eq   = ((src_now ^ flow_compare_value[f]) & eff_mask) == '0;
            dst_eq   = ((dst_now ^ flow_compare_value[f]) & eff_mask) == '0;
            if (comparator_protocol_select == iafc_pkg::MODE_IPV4 ||
                comparator_protocol_select == iafc_pkg::MODE_IPV6) begin
                case (address_select[f])
                    `IAFC_SEL_SRC:    addr_eq = src_eq;
                    `IAFC_SEL_DST:    addr_eq = dst_eq;
                    `IAFC_SEL_EITHER: addr_eq = src_eq || dst_eq;
                    default:          addr_eq = 1'b0;
                endcase
            end else begin
                addr_eq = src_eq;
            end
            next_match[f] = flow_enable_bit[f] && flow_channel_enable[f][BYTE_FIRST_IN ? CHAN_IN : frame_chan]
                            && addr_eq;
        end
    end

    // pass-through towards the last analyzer stage, one cycle late
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            BYTE_VALID_OUT <= 1'b0;
            BYTE_FIRST_OUT <= 1'b0;
            BYTE_LAST_OUT  <= 1'b0;
            BYTE_DATA_OUT  <= 8'h00;
        end else if (CE_IN) begin
            BYTE_VALID_OUT <= take;
            BYTE_FIRST_OUT <= take && BYTE_FIRST_IN;
            BYTE_LAST_OUT  <= take && BYTE_LAST_IN;
            // zeroing keeps byte slots
            BYTE_DATA_OUT  <= (take && udp_sum_zero_enable && in_sum_bytes) ? 8'h00 : BYTE_DATA_IN;
        end
    end

    // verdict and checksum hand-off, latched with the last byte
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            MATCH_VALID_OUT   <= 1'b0;
            FLOW_MATCH_OUT    <= '0;
            last_match        <= '0;
            PTP_KEY_OUT       <= 64'h0;
            SUM_ZERO_OUT      <= 1'b0;
            SUM_FIX_OUT       <= 1'b0;
            SUM_POS_OUT       <= 8'h00;
            SUM_POS_VALID_OUT <= 1'b0;
            SUM_LEN_OUT       <= 2'h0;
            SIG_POS_OUT       <= 5'h00;
        end else if (CE_IN) begin
            MATCH_VALID_OUT <= take && BYTE_LAST_IN;

            if (take && BYTE_LAST_IN) begin
                FLOW_MATCH_OUT    <= next_match;
                last_match        <= next_match;
                PTP_KEY_OUT       <= key_now;
                SUM_ZERO_OUT      <= udp_sum_zero_enable;
                SUM_FIX_OUT       <= udp_sum_fix_enable;
                SUM_POS_OUT       <= udp_sum_position;
                SUM_POS_VALID_OUT <= comparator_protocol_select == iafc_pkg::MODE_IPV4;
                SUM_LEN_OUT       <= udp_sum_length;
                SIG_POS_OUT       <= signature_field_position;
            end
        end
    end

endmodule : iafc_flow_comparator

// *** design/iafc_pkg.sv ***
// types shared by the flow comparator
package iafc_pkg;

    typedef enum logic [1:0] {
        MODE_IPV4,
        MODE_IPV6,
        MODE_OTHER32,
        MODE_OTHER128
    } iafc_mode_e;

    typedef enum logic {
        ST_IDLE,
        ST_FRAME
    } iafc_state_e;

    typedef logic [127:0] iafc_field_t;

endpackage : iafc_pkg

// *** design/unused_placeholder.sv ***
// intentionally empty
`timescale 1ns/1ps
